// ---- common/step_up_clock_params.svh ----
`ifndef STEP_UP_CLOCK_PARAMS_SVH
`define STEP_UP_CLOCK_PARAMS_SVH

// command codes on the display bus
`define CMD_NORMAL_PUMP 8'hc2
`define CMD_IDLE_PUMP 8'hc3
`define CMD_PARTIAL_PUMP 8'hc4

// parameter byte layout and reset value
`define PUMP_PARAM_RESET 8'h33
`define PUMP_CODE_RESET 3'h3
`define LOW_FIELD_LSB 0
`define HIGH_FIELD_LSB 4
`define FIELD_W 3
`define CODE_MAX 3'h4

// periods counted in eighths of a line: low 1..16, high 4..64
`define LOW_BASE_SHIFT 0
`define HIGH_BASE_SHIFT 2
`define EIGHTH_SHIFT 3
`define PERIOD_W 7
`define LINE_LEN_RESET 16'h0100

`endif

// ---- common/step_up_clock_pkg.sv ----
package step_up_clock_pkg;

    typedef enum logic [1:0] {
        tgt_none,
        tgt_normal,
        tgt_idle,
        tgt_partial
    } target_e;

    typedef enum logic [1:0] {
        mode_normal,
        mode_idle,
        mode_partial
    } disp_mode_e;

endpackage : step_up_clock_pkg

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ps

module host_bus_model (
    input wire logic ref_clk,
    output logic wr_strobe,
    output logic is_param,
    output logic [7:0] wr_data
);
    initial begin
        wr_strobe = 1'b0;
        is_param = 1'b0;
        wr_data = 8'h00;
    end

    // kind and data are scrambled once the strobe drops so nothing leans on stale values
    task automatic put_byte(input logic kind, input logic [7:0] b);
        @(posedge ref_clk);
        wr_strobe <= 1'b1;
        is_param <= kind;
        wr_data <= b;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
        is_param <= ~kind;
        wr_data <= ~b;
    endtask : put_byte
endmodule : host_bus_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps

module tb;
    import step_up_clock_pkg::*;
    localparam int LINE_LEN = 64;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic idle_mode = 1'b0;
    logic partial_mode = 1'b0;
    logic line_start = 1'b0;
    logic wr_strobe, is_param, pump_low_tick, pump_high_tick;
    logic [7:0] wr_data;
    logic [2:0] low_cycle_code, high_cycle_code;
    logic [1:0] active_mode;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int lcnt = 0;
    int seed = 56667;
    int model_reg[3];

    host_bus_model u_host (.ref_clk(ref_clk), .wr_strobe(wr_strobe), .is_param(is_param),
        .wr_data(wr_data));

    step_up_clock_select u_dut (.ref_clk(ref_clk), .rst(rst), .wr_strobe(wr_strobe),
        .is_param(is_param), .wr_data(wr_data), .idle_mode(idle_mode),
        .partial_mode(partial_mode), .line_start(line_start), .pump_low_tick(pump_low_tick),
        .pump_high_tick(pump_high_tick), .low_cycle_code(low_cycle_code),
        .high_cycle_code(high_cycle_code), .active_mode(active_mode));

    always #4 ref_clk = ~ref_clk;

    // a line of 64 clocks keeps eighths exact, so tick spacing has no remainder
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        lcnt <= (lcnt == LINE_LEN - 1) ? 0 : lcnt + 1;
        line_start <= (lcnt == LINE_LEN - 1);
    end

    always @(posedge ref_clk) begin
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // reference: only the three pump commands arm, reserved fields leave old value
    task automatic send(input int cmd, input int prm, input bit with_cmd);
        int i;
        i = cmd - 'hc2;
        if (with_cmd) u_host.put_byte(1'b0, 8'(cmd));
        u_host.put_byte(1'b1, 8'(prm));
        if (with_cmd && i >= 0 && i <= 2) begin
            if (((prm >> 4) & 7) <= 4) model_reg[i] = (model_reg[i] & 'h0f) | (prm & 'h70);
            if ((prm & 7) <= 4) model_reg[i] = (model_reg[i] & 'h70) | (prm & 7);
        end
    endtask : send

    task automatic check_codes();
        int m;
        // mode is read once the line starts, so a mode change just made has settled
        @(posedge line_start);
        m = idle_mode ? 1 : (partial_mode ? 2 : 0);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("active_mode", 16'(m), {14'h0, active_mode});
        chk("low_cycle_code", 16'(model_reg[m] & 7), {13'h0, low_cycle_code});
        chk("high_cycle_code", 16'(model_reg[m] >> 4), {13'h0, high_cycle_code});
    endtask : check_codes

    task automatic meas(input bit hi, input string what, input int exp_len);
        int n, k, t;
        n = 0;
        k = 0;
        t = 0;
        while (k < 2 && t < 2000) begin
            @(posedge ref_clk);
            #1;
            t++;
            if (k == 1) n++;
            if ((hi ? pump_high_tick : pump_low_tick) === 1'b1) k++;
        end
        chk(what, 16'(exp_len), 16'(n));
    endtask : meas

    initial begin
        int lo, hi, m;
        model_reg = '{'h33, 'h33, 'h33};
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("reset low code", 16'h0003, {13'h0, low_cycle_code});
        chk("reset high code", 16'h0003, {13'h0, high_cycle_code});
        $display("test reset done");
        // the first line after reset is cut short, so let the design measure a full one
        repeat (2) @(posedge line_start);
        for (int mi = 0; mi < 4; mi++) begin
            @(posedge ref_clk);
            idle_mode <= mi[0];
            partial_mode <= mi[1];
            for (int r = 0; r < 3; r++) begin
                lo = $unsigned($random(seed)) % 5;
                hi = $unsigned($random(seed)) % 5;
                send('hc2 + r, (hi << 4) | lo, 1'b1);
            end
            check_codes();
            m = mi[0] ? 1 : (mi[1] ? 2 : 0);
            lo = (LINE_LEN / 8) << (model_reg[m] & 7);
            hi = (LINE_LEN / 2) << ((model_reg[m] >> 4) & 7);
            meas(1'b0, "low period", lo);
            meas(1'b1, "high period", hi);
            $display("test mode %0d done", mi);
        end
        // refusals: stray bits, orphan and extra parameters, foreign command, reserved codes
        send('hc2, 'h8a, 1'b1);
        send(0, 'h41, 1'b0);
        send('hc5, 'h11, 1'b1);
        send(0, 'h44, 1'b0);
        send('hc3, 'h75, 1'b1);
        send('hc4, 'h52, 1'b1);
        for (int mi = 0; mi < 3; mi++) begin
            @(posedge ref_clk);
            idle_mode <= (mi == 1);
            partial_mode <= (mi == 2);
            check_codes();
        end
        $display("test refusals done");
        wrap_up();
    end
endmodule : tb

// ---- src/pump_clock_gen.sv ----
`timescale 1ns/1ps
`include "step_up_clock_params.svh"

module pump_clock_gen
    import step_up_clock_pkg::*;
#(
    parameter int BASE_SHIFT = 0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic line_pulse,
    input wire logic eighth_tick,
    input wire logic [2:0] code_sel,
    output logic [2:0] code_out,
    output logic pump_tick
);

    typedef struct packed {
        logic [2:0] code;
        logic [`PERIOD_W-1:0] count;
        logic tick;
    } gen_s;

    gen_s st_reg;
    gen_s st_next;
    logic [`PERIOD_W-1:0] period;
    logic change;

    // one pump pulse every 2^(code+base) eighths of a line
    assign period = `PERIOD_W'(1) << (st_reg.code + 3'(BASE_SHIFT));
    assign change = line_pulse && (code_sel != st_reg.code);

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (change) begin
            // new cycle only at a line boundary, restarting the phase there
            st_next.code = code_sel;
            st_next.count = '0;
        end else if (eighth_tick) begin
            if (st_next.count == period - `PERIOD_W'(1)) begin
                st_next.count = '0;
                st_next.tick = 1'b1;
            end else begin
                st_next.count = st_next.count + `PERIOD_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '{code: `PUMP_CODE_RESET, count: '0, tick: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign code_out = st_reg.code;
    assign pump_tick = st_reg.tick;

    a_period_fires: assert property (@(posedge ref_clk) disable iff (rst)
        eighth_tick && !change && st_reg.count == period - `PERIOD_W'(1) |=> pump_tick)
        else $error("pump pulse missing at end of period");

    a_no_early_tick: assert property (@(posedge ref_clk) disable iff (rst)
        pump_tick |-> $past(st_reg.count) == $past(period) - `PERIOD_W'(1))
        else $error("pump pulse before period end");

    a_code_at_line: assert property (@(posedge ref_clk) disable iff (rst)
        !line_pulse |=> $stable(code_out))
        else $error("pump cycle changed between line boundaries");

endmodule : pump_clock_gen

// ---- src/step_up_clock_select.sv ----
`timescale 1ns/1ps
`include "step_up_clock_params.svh"

// How it works
// - normal command C2h, one byte, default 33h
// - idle command C3h, same layout, default 33h
// - partial command C4h, same layout, default 33h
// - normal mode: circuits 1/4/5 use normal low
// - normal mode: circuits 2/3 use normal high
// - idle mode: circuits 1/4/5 use idle low
// - idle mode: circuits 2/3 use idle high
// - partial mode: circuits 1/4/5 use partial low
// - partial mode: circuits 2/3 use partial high
// - low codes: 1/8, 1/4, 1/2, 1, 2 H
// - high codes: 1/2, 1, 2, 4, 8 H
module step_up_clock_select
    import step_up_clock_pkg::*;
#(
    parameter int LINE_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_strobe,
    input wire logic is_param,
    input wire logic [7:0] wr_data,
    input wire logic idle_mode,
    input wire logic partial_mode,
    input wire logic line_start,
    output logic pump_low_tick,
    output logic pump_high_tick,
    output logic [2:0] low_cycle_code,
    output logic [2:0] high_cycle_code,
    output logic [1:0] active_mode
);

    typedef struct packed {
        target_e target;
        logic [7:0] normal_mode_pump_clock;
        logic [7:0] idle_mode_pump_clock;
        logic [7:0] partial_mode_pump_clock;
        disp_mode_e mode;
        logic [LINE_W-1:0] line_cnt;
        logic [LINE_W-1:0] line_len;
        logic [LINE_W-1:0] eighth_cnt;
        logic eighth_tick;
        logic line_pulse;
    } state_s;

    state_s st_reg;
    state_s st_next;

    ////////////////////////////////////////////////////////////////////////////
    // field helpers

    function automatic logic [7:0] merge_param(input logic [7:0] old_val,
                                               input logic [7:0] new_val);
        logic [7:0] res;
        res = old_val;
        res[7] = 1'b0;
        res[3] = 1'b0;
        // reserved codes leave the field as it was, so a bad write cannot stop a pump
        if (new_val[`LOW_FIELD_LSB +: `FIELD_W] <= `CODE_MAX) begin
            res[`LOW_FIELD_LSB +: `FIELD_W] = new_val[`LOW_FIELD_LSB +: `FIELD_W];
        end
        if (new_val[`HIGH_FIELD_LSB +: `FIELD_W] <= `CODE_MAX) begin
            res[`HIGH_FIELD_LSB +: `FIELD_W] = new_val[`HIGH_FIELD_LSB +: `FIELD_W];
        end
        return res;
    endfunction : merge_param

    logic [7:0] sel_param;
    logic [2:0] sel_low;
    logic [2:0] sel_high;
    logic [LINE_W-1:0] eighth_len;

    always_comb begin
        case (st_reg.mode)
            mode_idle: sel_param = st_reg.idle_mode_pump_clock;
            mode_partial: sel_param = st_reg.partial_mode_pump_clock;
            default: sel_param = st_reg.normal_mode_pump_clock;
        endcase
    end

    assign sel_low = sel_param[`LOW_FIELD_LSB +: `FIELD_W];
    assign sel_high = sel_param[`HIGH_FIELD_LSB +: `FIELD_W];

    // a line shorter than eight clocks still gets one tick per clock
    assign eighth_len = ((st_reg.line_len >> `EIGHTH_SHIFT) == '0) ?
        LINE_W'(1) : (st_reg.line_len >> `EIGHTH_SHIFT);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        st_next.eighth_tick = 1'b0;
        st_next.line_pulse = 1'b0;

        // command byte arms one parameter; any other command disarms
        if (wr_strobe && !is_param) begin
            case (wr_data)
                `CMD_NORMAL_PUMP: st_next.target = tgt_normal;
                `CMD_IDLE_PUMP: st_next.target = tgt_idle;
                `CMD_PARTIAL_PUMP: st_next.target = tgt_partial;
                default: st_next.target = tgt_none;
            endcase
        end else if (wr_strobe && is_param) begin
            case (st_reg.target)
                tgt_normal: st_next.normal_mode_pump_clock =
                    merge_param(st_reg.normal_mode_pump_clock, wr_data);
                tgt_idle: st_next.idle_mode_pump_clock =
                    merge_param(st_reg.idle_mode_pump_clock, wr_data);
                tgt_partial: st_next.partial_mode_pump_clock =
                    merge_param(st_reg.partial_mode_pump_clock, wr_data);
                default: ;
            endcase
            st_next.target = tgt_none;
        end

        // idle takes priority over both partial and normal
        if (idle_mode) begin
            st_next.mode = mode_idle;
        end else if (partial_mode) begin
            st_next.mode = mode_partial;
        end else begin
            st_next.mode = mode_normal;
        end

        // measure the line period and split it into eighths
        if (line_start) begin
            st_next.line_len = st_reg.line_cnt + LINE_W'(1);
            st_next.line_cnt = '0;
            st_next.eighth_cnt = '0;
            st_next.eighth_tick = 1'b1;
            st_next.line_pulse = 1'b1;
        end else begin
            if (st_reg.line_cnt != '1) begin
                st_next.line_cnt = st_reg.line_cnt + LINE_W'(1);
            end
            if (st_reg.eighth_cnt >= eighth_len - LINE_W'(1)) begin
                st_next.eighth_cnt = '0;
                st_next.eighth_tick = 1'b1;
            end else begin
                st_next.eighth_cnt = st_reg.eighth_cnt + LINE_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '{
                target: tgt_none,
                normal_mode_pump_clock: `PUMP_PARAM_RESET,
                idle_mode_pump_clock: `PUMP_PARAM_RESET,
                partial_mode_pump_clock: `PUMP_PARAM_RESET,
                mode: mode_normal,
                line_cnt: '0,
                line_len: LINE_W'(`LINE_LEN_RESET),
                eighth_cnt: '0,
                eighth_tick: 1'b0,
                line_pulse: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign active_mode = st_reg.mode;

    ////////////////////////////////////////////////////////////////////////////
    // pump clock generators

    pump_clock_gen #(
        .BASE_SHIFT(`LOW_BASE_SHIFT)
    ) low_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .line_pulse(st_reg.line_pulse),
        .eighth_tick(st_reg.eighth_tick),
        .code_sel(sel_low),
        .code_out(low_cycle_code),
        .pump_tick(pump_low_tick)
    );

    pump_clock_gen #(
        .BASE_SHIFT(`HIGH_BASE_SHIFT)
    ) high_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .line_pulse(st_reg.line_pulse),
        .eighth_tick(st_reg.eighth_tick),
        .code_sel(sel_high),
        .code_out(high_cycle_code),
        .pump_tick(pump_high_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_normal_param: assert property (@(posedge ref_clk) disable iff (rst)
        wr_strobe && is_param && st_reg.target == tgt_normal
        && wr_data[2:0] <= `CODE_MAX && wr_data[6:4] <= `CODE_MAX
        |=> st_reg.normal_mode_pump_clock == {1'b0, $past(wr_data[6:4]), 1'b0,
            $past(wr_data[2:0])})
        else $error("normal pump byte not stored");

    a_idle_param: assert property (@(posedge ref_clk) disable iff (rst)
        wr_strobe && is_param && st_reg.target == tgt_idle && wr_data[2:0] <= `CODE_MAX
        |=> st_reg.idle_mode_pump_clock[2:0] == $past(wr_data[2:0]))
        else $error("idle pump byte not stored");

    a_partial_param: assert property (@(posedge ref_clk) disable iff (rst)
        wr_strobe && is_param && st_reg.target == tgt_partial
        && wr_data[6:4] <= `CODE_MAX
        |=> st_reg.partial_mode_pump_clock[6:4] == $past(wr_data[6:4])
            && st_reg.target == tgt_none)
        else $error("partial pump byte not stored");

    a_normal_low: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.line_pulse && st_reg.mode == mode_normal
        |=> low_cycle_code == $past(st_reg.normal_mode_pump_clock[2:0]))
        else $error("normal low cycle not applied");

    a_normal_high: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.line_pulse && st_reg.mode == mode_normal
        |=> high_cycle_code == $past(st_reg.normal_mode_pump_clock[6:4]))
        else $error("normal high cycle not applied");

    a_idle_both: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.line_pulse && st_reg.mode == mode_idle
        |=> low_cycle_code == $past(st_reg.idle_mode_pump_clock[2:0])
            && high_cycle_code == $past(st_reg.idle_mode_pump_clock[6:4]))
        else $error("idle cycles not applied");

    a_partial_both: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.line_pulse && st_reg.mode == mode_partial
        |=> low_cycle_code == $past(st_reg.partial_mode_pump_clock[2:0])
            && high_cycle_code == $past(st_reg.partial_mode_pump_clock[6:4]))
        else $error("partial cycles not applied");

    a_idle_priority: assert property (@(posedge ref_clk) disable iff (rst)
        idle_mode && partial_mode |=> active_mode == mode_idle)
        else $error("idle did not win over partial");

    a_reserved_kept: assert property (@(posedge ref_clk) disable iff (rst)
        wr_strobe && is_param && st_reg.target == tgt_idle && wr_data[2:0] > `CODE_MAX
        |=> $stable(st_reg.idle_mode_pump_clock[2:0]))
        else $error("reserved code changed a field");

endmodule : step_up_clock_select
